//--- src/ast_pkg.sv
// shared constants and types for the converter sequencer and its trigger source
package ast_pkg;
   // software port map (register indices are byte offsets on an 8-bit port)
   localparam logic [3:0] OFS_RESULT_HIGH  = 4'h0;
   localparam logic [3:0] OFS_RESULT_LOW   = 4'h1;
   localparam logic [3:0] OFS_CONTROL      = 4'h2;
   localparam logic [3:0] OFS_REF_PORT     = 4'h3;
   localparam logic [3:0] OFS_TIMING       = 4'h4;
   localparam logic [3:0] OFS_IRQ_STATUS   = 4'h5;
   localparam logic [3:0] OFS_IRQ_MASK     = 4'h6;
   localparam logic [3:0] OFS_SAMPLE_DATA  = 4'h7;
   // trigger source map
   localparam logic [3:0] OFS_CMP_CONTROL  = 4'h0;
   localparam logic [3:0] OFS_CMP_MATCH_LO = 4'h1;
   localparam logic [3:0] OFS_CMP_MATCH_HI = 4'h2;
   localparam logic [3:0] OFS_CMP_COUNT_LO = 4'h3;
   localparam logic [3:0] OFS_CMP_COUNT_HI = 4'h4;
   localparam logic [3:0] OFS_CMP_STATUS   = 4'h5;
   localparam logic [3:0] OFS_CMP_MASK     = 4'h6;
   // control and timing register fields
   localparam int         BIT_ENABLE       = 0;
   localparam int         BIT_GO           = 1;
   localparam int         CHS_LSB          = 2;
   localparam logic [7:0] MASK_CONTROL     = 8'h3F;
   localparam logic [7:0] MASK_REF_PORT    = 8'h3F;
   localparam logic [7:0] MASK_TIMING      = 8'hBF;
   localparam int         BIT_JUSTIFY      = 7;
   localparam int         ACQ_LSB          = 3;
   localparam int         CLK_LSB          = 0;
   // reset values
   localparam logic [7:0] RST_CONTROL      = 8'h00;
   localparam logic [7:0] RST_REF_PORT     = 8'h00;
   localparam logic [7:0] RST_TIMING       = 8'h00;
   localparam logic [7:0] RST_BYTE         = 8'h00;
   // compare mode code that fires the special event
   localparam logic [3:0] MODE_SPECIAL_EVT = 4'hB;
   localparam int         BIT_CMP_MATCH    = 0;
   // conversion timing in conversion-clock periods
   localparam logic [4:0] CONV_PERIODS     = 5'h0B;
   localparam logic [4:0] POST_WAIT        = 5'h02;
   localparam logic [4:0] DISCHARGE_PER    = 5'h01;
   // internal rc conversion clock divider (terminal count, one less than system clocks per period)
   localparam logic [6:0] RC_DIV           = 7'h7F;
   // interrupt bits
   localparam int         IRQ_DONE         = 0;
   localparam int         IRQ_TRIG         = 1;
   localparam int         IRQ_ABORT        = 2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_DISCHARGE, ST_ACQUIRE, ST_CONVERT, ST_WAIT
   } ast_state_t;
endpackage

//--- src/ast_link_if.sv
// link between the compare unit and the converter sequencer
interface ast_link_if;
   logic       special_event;   // one-cycle pulse from compare unit
   logic [3:0] compare_mode;    // compare_mode_field as programmed
   modport conv (input  special_event, input  compare_mode);
   modport cmp  (output special_event, output compare_mode);
endinterface

//--- src/ast_tad_gen.sv
// conversion clock tick generator: oscillator divider or internal rc divider
module ast_tad_gen
   import ast_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   // control
   input  wire logic       run,
   input  wire logic [2:0] clk_sel,
   // tick out
   output logic            tick
);
   import ast_pkg::*;

   logic [6:0] cnt_reg;
   logic [6:0] limit;
   logic       rc_sel;

   // code x11 picks the rc source, else 2^(n+1) oscillator periods with n = {clk_sel[1:0], clk_sel[2]}
   assign rc_sel = (clk_sel[1:0] == 2'h3);
   assign limit  = rc_sel ? RC_DIV :
                   7'((7'h02 << {clk_sel[1:0], clk_sel[2]}) - 7'h01);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= 7'h00;
         tick    <= 1'b0;
      end else if (clk_en) begin
         if (!run || cnt_reg >= limit) begin
            cnt_reg <= 7'h00;
         end else begin
            cnt_reg <= 7'(cnt_reg + 7'h01);
         end
         tick <= run && (cnt_reg >= limit);
      end
   end
endmodule // ast_tad_gen

//--- src/ast_converter.sv
// converter sequencer end: registers, trigger intake, sample and convert sequence
module ast_converter
   import ast_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   // link to compare unit
   ast_link_if.conv        link,
   // software port
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // analog front end
   input  wire logic [9:0] sample_code,
   output logic            sample_switch,
   output logic            discharge,
   output logic      [3:0] channel,
   output logic            irq
);
   import ast_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  control_reg, ref_reg, timing_reg;
   logic [7:0]  res_hi_reg, res_lo_reg;
   logic [2:0]  status_reg, mask_reg;
   logic [4:0]  cnt_reg;
   ast_state_t  state_reg;
   logic        evt_s1_reg, evt_s2_reg, evt_s3_reg, mode_ok_reg;
   logic [3:0]  mode_s1_reg, mode_s2_reg;
   logic        tick;
   logic        busy, evt_edge, trig_ok, sw_go, sw_stop, done_now, abort_now;
   logic [4:0]  acq_len;
   logic [2:0]  acq_code;
   logic [15:0] justified;
   logic        wr_ctl, wr_ref, wr_tim, wr_hi, wr_lo, wr_st, wr_mk;
   logic [7:0]  rd_mux;

   assign wr_ctl = wr && addr == OFS_CONTROL;
   assign wr_ref = wr && addr == OFS_REF_PORT;
   assign wr_tim = wr && addr == OFS_TIMING;
   assign wr_hi  = wr && addr == OFS_RESULT_HIGH;
   assign wr_lo  = wr && addr == OFS_RESULT_LOW;
   assign wr_st  = wr && addr == OFS_IRQ_STATUS;
   assign wr_mk  = wr && addr == OFS_IRQ_MASK;

   ////////////////////////////////////////////////////////////////////////
   // the pulse and mode come from another block's logic but are treated as
   // asynchronous so the converter may sit in its own clock gating domain
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         evt_s1_reg  <= 1'b0;
         evt_s2_reg  <= 1'b0;
         evt_s3_reg  <= 1'b0;
         mode_s1_reg <= 4'h0;
         mode_s2_reg <= 4'h0;
         mode_ok_reg <= 1'b0;
      end else if (clk_en) begin
         evt_s1_reg  <= link.special_event;
         evt_s2_reg  <= evt_s1_reg;
         evt_s3_reg  <= evt_s2_reg;
         mode_s1_reg <= link.compare_mode;
         mode_s2_reg <= mode_s1_reg;
         mode_ok_reg <= mode_s2_reg == MODE_SPECIAL_EVT;
      end
   end

   assign evt_edge = evt_s2_reg && !evt_s3_reg;
   assign busy     = state_reg != ST_IDLE;
   assign trig_ok  = evt_edge && mode_ok_reg && control_reg[BIT_ENABLE] && !busy;
   // start/done in bit 1, enable in bit 0
   assign sw_go    = wr_ctl && wdata[BIT_GO] && !control_reg[BIT_GO]
                     && control_reg[BIT_ENABLE];
   assign sw_stop  = wr_ctl && !wdata[BIT_GO] && control_reg[BIT_GO];

   assign acq_code = timing_reg[ACQ_LSB +: 3];
   always_comb begin
      case (acq_code)
         3'h1:    acq_len = 5'h02;
         3'h2:    acq_len = 5'h04;
         3'h3:    acq_len = 5'h06;
         3'h4:    acq_len = 5'h08;
         3'h5:    acq_len = 5'h0C;
         3'h6:    acq_len = 5'h10;
         3'h7:    acq_len = 5'h14;
         default: acq_len = 5'h00;
      endcase
   end

   ast_tad_gen u_tad (
      .clock   (clock),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .run     (busy),
      .clk_sel (timing_reg[CLK_LSB +: 3]),
      .tick    (tick)
   );

   // eleven periods per conversion
   // an abort in the finishing period wins, so the result is never loaded then
   assign done_now  = state_reg == ST_CONVERT && tick && !sw_stop
                      && cnt_reg == CONV_PERIODS - 5'h01;
   // abort when start bit cleared mid-sequence
   assign abort_now = sw_stop && (state_reg == ST_ACQUIRE || state_reg == ST_CONVERT
                                  || state_reg == ST_DISCHARGE);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 5'h00;
      end else if (clk_en) begin
         case (state_reg)
            ST_IDLE: begin
               cnt_reg <= 5'h00;
               if (trig_ok || sw_go) begin
                  state_reg <= ST_DISCHARGE;
               end
            end
            ST_DISCHARGE: begin
               if (abort_now) begin
                  state_reg <= ST_WAIT;
               end else if (tick) begin
                  state_reg <= (acq_len == 5'h00) ? ST_CONVERT : ST_ACQUIRE;
               end
            end
            ST_ACQUIRE: begin
               if (abort_now) begin
                  state_reg <= ST_WAIT;
                  cnt_reg   <= 5'h00;
               end else if (tick) begin
                  if (cnt_reg == acq_len - 5'h01) begin
                     state_reg <= ST_CONVERT;
                     cnt_reg   <= 5'h00;
                  end else begin
                     cnt_reg <= 5'(cnt_reg + 5'h01);
                  end
               end
            end
            ST_CONVERT: begin
               if (abort_now) begin
                  state_reg <= ST_WAIT;
                  cnt_reg   <= 5'h00;
               end else if (done_now) begin
                  state_reg <= ST_WAIT;
                  cnt_reg   <= 5'h00;
               end else if (tick) begin
                  cnt_reg <= 5'(cnt_reg + 5'h01);
               end
            end
            // two-period wait after done or abort
            ST_WAIT: begin
               if (tick) begin
                  if (cnt_reg == POST_WAIT - 5'h01) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     cnt_reg <= 5'(cnt_reg + 5'h01);
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // justification of ten-bit result
   // taken straight from the front end so the finishing conversion lands
   assign justified = timing_reg[BIT_JUSTIFY] ? {6'h00, sample_code}
                                              : {sample_code, 6'h00};

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         control_reg <= RST_CONTROL;
         ref_reg     <= RST_REF_PORT;
         timing_reg  <= RST_TIMING;
         res_hi_reg  <= RST_BYTE;
         res_lo_reg  <= RST_BYTE;
         status_reg  <= 3'h0;
         mask_reg    <= 3'h0;
      end else if (clk_en) begin
         if (wr_ctl) control_reg <= wdata & MASK_CONTROL;
         if (wr_ref) ref_reg     <= wdata & MASK_REF_PORT;
         if (wr_tim) timing_reg  <= wdata & MASK_TIMING;
         if (trig_ok) control_reg[BIT_GO] <= 1'b1;
         // start bit cleared when the conversion finishes
         if (done_now) control_reg[BIT_GO] <= 1'b0;
         if (done_now) begin
            res_hi_reg <= justified[15:8];
            res_lo_reg <= justified[7:0];
         end else begin
            if (wr_hi) res_hi_reg <= wdata;
            if (wr_lo) res_lo_reg <= wdata;
         end
         if (wr_mk) mask_reg <= wdata[2:0];
         // done, trigger and abort flags set, set beats clear
         status_reg <= (status_reg & ~(wr_st ? wdata[2:0] : 3'h0))
                       | {abort_now, trig_ok, done_now};
      end
   end

   always_comb begin
      case (addr)
         OFS_RESULT_HIGH: rd_mux = res_hi_reg;
         OFS_RESULT_LOW:  rd_mux = res_lo_reg;
         OFS_CONTROL:     rd_mux = control_reg;
         OFS_REF_PORT:    rd_mux = ref_reg;
         OFS_TIMING:      rd_mux = timing_reg;
         OFS_IRQ_STATUS:  rd_mux = {5'h00, status_reg};
         OFS_IRQ_MASK:    rd_mux = {5'h00, mask_reg};
         default:         rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata         <= 8'h00;
         irq           <= 1'b0;
         sample_switch <= 1'b0;
         discharge     <= 1'b0;
         channel       <= 4'h0;
      end else if (clk_en) begin
         rdata         <= rd ? rd_mux : 8'h00;
         irq           <= |(status_reg & mask_reg);
         // sampling runs whenever enabled and idle or acquiring
         sample_switch <= control_reg[BIT_ENABLE] &&
                          (state_reg == ST_IDLE || state_reg == ST_ACQUIRE);
         discharge     <= state_reg == ST_DISCHARGE;
         channel       <= control_reg[CHS_LSB +: 4];
      end
   end
endmodule // ast_converter

//--- src/ast_compare.sv
// compare unit end: sixteen-bit counter, match register, special event output
module ast_compare
   import ast_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   // link to converter
   ast_link_if.cmp         link,
   // software port
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   output logic            irq
);
   import ast_pkg::*;

   logic [3:0]  mode_reg;
   logic [15:0] match_reg, count_reg;
   logic        status_reg, mask_reg, evt_reg;
   logic        hit;
   logic [7:0]  rd_mux;

   // special event only in mode 1011
   assign hit = mode_reg == MODE_SPECIAL_EVT && count_reg == match_reg;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_reg   <= 4'h0;
         match_reg  <= 16'hFFFF;
         count_reg  <= 16'h0000;
         status_reg <= 1'b0;
         mask_reg   <= 1'b0;
         evt_reg    <= 1'b0;
         rdata      <= 8'h00;
         irq        <= 1'b0;
      end else if (clk_en) begin
         if (wr && addr == OFS_CMP_CONTROL)  mode_reg        <= wdata[3:0];
         if (wr && addr == OFS_CMP_MATCH_LO) match_reg[7:0]  <= wdata;
         if (wr && addr == OFS_CMP_MATCH_HI) match_reg[15:8] <= wdata;
         if (wr && addr == OFS_CMP_MASK)     mask_reg        <= wdata[BIT_CMP_MATCH];
         if (hit) begin
            count_reg <= 16'h0000;
         end else if (wr && addr == OFS_CMP_COUNT_LO) begin
            count_reg[7:0] <= wdata;
         end else if (wr && addr == OFS_CMP_COUNT_HI) begin
            count_reg[15:8] <= wdata;
         end else begin
            count_reg <= 16'(count_reg + 16'h0001);
         end
         evt_reg    <= hit;
         status_reg <= (status_reg && !(wr && addr == OFS_CMP_STATUS
                        && wdata[BIT_CMP_MATCH])) || hit;
         irq        <= status_reg && mask_reg;
         rdata      <= rd ? rd_mux : 8'h00;
      end
   end

   always_comb begin
      case (addr)
         OFS_CMP_CONTROL:  rd_mux = {4'h0, mode_reg};
         OFS_CMP_MATCH_LO: rd_mux = match_reg[7:0];
         OFS_CMP_MATCH_HI: rd_mux = match_reg[15:8];
         OFS_CMP_COUNT_LO: rd_mux = count_reg[7:0];
         OFS_CMP_COUNT_HI: rd_mux = count_reg[15:8];
         OFS_CMP_STATUS:   rd_mux = {7'h00, status_reg};
         OFS_CMP_MASK:     rd_mux = {7'h00, mask_reg};
         default:          rd_mux = 8'h00;
      endcase
   end

   assign link.special_event = evt_reg;
   assign link.compare_mode  = mode_reg;
endmodule // ast_compare

//--- bench/ast_link_checker.sv
// concurrent checks on the compare-to-converter link and the sampling front end
module ast_link_checker
   import ast_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // link between the two ends
   input  wire logic       special_event,
   input  wire logic [3:0] compare_mode,
   // analog front end of the converter
   input  wire logic       discharge,
   input  wire logic       sample_switch
);
   timeunit 1ns;
   timeprecision 100ps;
   import ast_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////////////////////////
   // trigger is pulse
   a_event_single: assert property (special_event |=> !special_event)
      else $error("special event held longer than one cycle");
   a_trigger_starts: assert property (
      special_event && compare_mode == MODE_SPECIAL_EVT && sample_switch
      |-> ##[2:6] discharge)
      else $error("accepted trigger did not start a discharge");
   a_trigger_synced: assert property (
      special_event |=> !$rose(discharge) ##1 !$rose(discharge))
      else $error("discharge began before the trigger was synchronised");
   ////////////////////////////////////////////////////////////////////////////////
   // array isolated while discharging
   a_discharge_isolated: assert property (discharge |-> !sample_switch)
      else $error("input sampled while the array discharges");
   a_discharge_min: assert property ($rose(discharge) |-> discharge [*2])
      else $error("discharge shorter than one conversion period");
   a_discharge_bounded: assert property ($rose(discharge) |-> ##[1:130] !discharge)
      else $error("discharge longer than one slowest period");
   a_discharge_gap: assert property ($fell(discharge) |=> !discharge [*8])
      else $error("new discharge before the conversion finished");
   a_mode_steady: assert property (special_event |-> $stable(compare_mode))
      else $error("compare mode changed as the trigger fired");
   c_trigger: cover property (special_event && sample_switch);
endmodule // ast_link_checker

//--- bench/tb_top.sv
// self-checking bench: converter and compare unit joined by the link interface
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ast_pkg::*;

   logic       clock;
   logic       nrst;
   logic [3:0] addr [2];
   logic [7:0] wdata [2];
   logic       wr [2];
   logic       rd [2];
   logic [7:0] rdata [2];
   logic [9:0] sample_code;
   logic       sample_switch;
   logic       discharge;
   logic       irq;
   logic       cmp_irq;
   logic [3:0] channel;
   int         failures;
   int         check_count;
   int         cyc;

   ast_link_if lnk ();
   ast_converter ast_converter_i (.clock(clock), .nrst(nrst), .clk_en(1'b1), .link(lnk),
      .addr(addr[0]), .wdata(wdata[0]), .wr(wr[0]), .rd(rd[0]), .rdata(rdata[0]),
      .sample_code(sample_code), .sample_switch(sample_switch), .discharge(discharge),
      .channel(channel), .irq(irq));
   ast_compare ast_compare_i (.clock(clock), .nrst(nrst), .clk_en(1'b1), .link(lnk),
      .addr(addr[1]), .wdata(wdata[1]), .wr(wr[1]), .rd(rd[1]), .rdata(rdata[1]),
      .irq(cmp_irq));
   ast_link_checker ast_link_checker_i (.clock(clock), .nrst(nrst),
      .special_event(lnk.special_event), .compare_mode(lnk.compare_mode),
      .discharge(discharge), .sample_switch(sample_switch));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // the ceiling is several times the slowest path, so a hang is cut short early
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task end_of_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one software port cycle; p picks the converter (0) or the compare unit (1)
   task acc(input int p, input bit w, input logic [3:0] a, input logic [7:0] d,
            output logic [7:0] q);
      @(posedge clock);
      addr[p] <= a;
      wdata[p] <= d;
      wr[p] <= w;
      rd[p] <= !w;
      @(posedge clock);
      wr[p] <= 1'b0;
      rd[p] <= 1'b0;
      #1 q = rdata[p];
   endtask

   task cw(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(0, 1'b1, a, d, q);
   endtask

   task pw(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(1, 1'b1, a, d, q);
   endtask

   task cr(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] q;
      acc(0, 1'b0, a, 8'h00, q);
      chk(q, e);
   endtask

   task wait_done(output int n);
      int         t0;
      logic [7:0] q;
      t0 = cyc;
      q = 8'h02;
      while (q[BIT_GO] === 1'b1 && cyc - t0 < 4000)
         acc(0, 1'b0, OFS_CONTROL, 8'h00, q);
      n = cyc - t0;
   endtask

   task wait_evt();
      int k;
      k = 0;
      while (lnk.special_event !== 1'b1 && k < 400) begin
         @(posedge clock);
         #1 k++;
      end
      chk({7'h0, lnk.special_event}, 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task t_reset();
      cr(OFS_CONTROL, RST_CONTROL);
      cr(OFS_REF_PORT, RST_REF_PORT);
      cr(OFS_TIMING, RST_TIMING);
      cr(OFS_RESULT_HIGH, RST_BYTE);
      cr(OFS_RESULT_LOW, RST_BYTE);
      cw(OFS_REF_PORT, 8'hFF);
      cr(OFS_REF_PORT, MASK_REF_PORT);
      cw(OFS_TIMING, 8'hFF);
      cr(OFS_TIMING, MASK_TIMING);
      cr(4'hF, 8'h00);
      cw(OFS_CONTROL, 8'hFD);
      cr(OFS_CONTROL, 8'h3D);
      chk({4'h0, channel}, 8'h0F);
      $display("test reset and layout done");
   endtask

   task t_soft();
      int n;
      cw(OFS_TIMING, 8'h80);
      cw(OFS_CONTROL, 8'h01);
      sample_code <= 10'h2A5;
      cw(OFS_CONTROL, 8'h03);
      wait_done(n);
      chk({7'h0, n >= 20 && n <= 34}, 8'h01);
      cr(OFS_RESULT_HIGH, 8'h02);
      cr(OFS_RESULT_LOW, 8'hA5);
      cr(OFS_IRQ_STATUS, 8'h01);
      chk({7'h0, irq}, 8'h00);
      cw(OFS_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clock);
      #1 chk({7'h0, irq}, 8'h01);
      cw(OFS_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge clock);
      #1 chk({7'h0, irq}, 8'h00);
      // left justified on the internal rc clock
      cw(OFS_TIMING, 8'h03);
      cw(OFS_CONTROL, 8'h03);
      wait_done(n);
      chk({7'h0, n >= 1400 && n <= 1900}, 8'h01);
      cr(OFS_RESULT_HIGH, 8'hA9);
      cr(OFS_RESULT_LOW, 8'h40);
      cw(OFS_IRQ_STATUS, 8'h01);
      $display("test software conversion done");
   endtask

   task t_abort();
      // the slow clock's closing wait must run out before a new start
      repeat (300) @(posedge clock);
      cw(OFS_TIMING, 8'h38);
      sample_code <= 10'h000;
      cw(OFS_CONTROL, 8'h03);
      repeat (10) @(posedge clock);
      cw(OFS_CONTROL, 8'h01);
      repeat (8) @(posedge clock);
      cr(OFS_IRQ_STATUS, 8'h04);
      cr(OFS_RESULT_HIGH, 8'hA9);
      cr(OFS_RESULT_LOW, 8'h40);
      cr(OFS_CONTROL, 8'h01);
      cw(OFS_IRQ_STATUS, 8'h04);
      $display("test abort done");
   endtask

   task t_trigger();
      int         n;
      logic [7:0] q;
      cw(OFS_TIMING, 8'h80);
      sample_code <= 10'h155;
      pw(OFS_CMP_MATCH_LO, 8'h40);
      pw(OFS_CMP_MATCH_HI, 8'h00);
      // counter brought near zero so the first match comes soon
      pw(OFS_CMP_COUNT_LO, 8'h00);
      pw(OFS_CMP_COUNT_HI, 8'h00);
      pw(OFS_CMP_CONTROL, {4'h0, MODE_SPECIAL_EVT});
      wait_evt();
      acc(1, 1'b0, OFS_CMP_COUNT_LO, 8'h00, q);
      chk({7'h0, q < 8'h08}, 8'h01);
      repeat (3) @(posedge clock);
      cr(OFS_CONTROL, 8'h03);
      wait_done(n);
      cr(OFS_RESULT_HIGH, 8'h01);
      cr(OFS_RESULT_LOW, 8'h55);
      cr(OFS_IRQ_STATUS, 8'h03);
      cw(OFS_IRQ_STATUS, 8'h03);
      // disabled converter: trigger ignored, counter still cleared
      cw(OFS_CONTROL, 8'h00);
      wait_evt();
      acc(1, 1'b0, OFS_CMP_COUNT_LO, 8'h00, q);
      chk({7'h0, q < 8'h08}, 8'h01);
      repeat (6) @(posedge clock);
      cr(OFS_CONTROL, 8'h00);
      cr(OFS_IRQ_STATUS, 8'h00);
      pw(OFS_CMP_MASK, 8'h01);
      @(posedge clock);
      #1 chk({7'h0, cmp_irq}, 8'h01);
      $display("test special event trigger done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      cyc = 0;
      failures = 0;
      check_count = 0;
      addr = '{4'h0, 4'h0};
      wdata = '{8'h00, 8'h00};
      wr = '{1'b0, 1'b0};
      rd = '{1'b0, 1'b0};
      sample_code = 10'h000;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      t_reset();
      t_soft();
      t_abort();
      t_trigger();
      end_of_test();
   end
endmodule // tb_top
